/* File: include/dma_diag_pkg.sv */
// Package with register offsets, field layouts and reset values of the DMA diagnostic block.
package dma_diag_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_DROP_CNT = 8'h00;
  localparam logic [7:0] OFF_CUR_TX_DESC = 8'h04;
  localparam logic [7:0] OFF_CUR_RX_DESC = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam int NOBUF_LSB = 0;
  localparam int NOBUF_W = 16;
  localparam int NOBUF_WRAP_BIT = 16;
  localparam int FIFO_LSB = 17;
  localparam int FIFO_W = 11;
  localparam int FIFO_WRAP_BIT = 28;
  localparam logic [15:0] NOBUF_MAX = 16'hFFFF;
  localparam logic [10:0] FIFO_MAX = 11'h7FF;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  localparam int IRQ_W = 4;
  localparam int IRQ_NOBUF_DROP = 0;
  localparam int IRQ_NOBUF_WRAP = 1;
  localparam int IRQ_FIFO_DROP = 2;
  localparam int IRQ_FIFO_WRAP = 3;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
endpackage

/* File: include/drop_evt_if.sv */
// Interface carrying one drop counter's event, read-clear and state.
`timescale 1ns/10ps
interface drop_evt_if #(parameter int W = 16);
  logic drop;
  logic rd_clr;
  logic [W-1:0] count;
  logic wrapped;
  logic wrap_pulse;
  modport ctr(input drop, input rd_clr, output count, output wrapped, output wrap_pulse);
  modport top(output drop, output rd_clr, input count, input wrapped, input wrap_pulse);
endinterface

/* File: hdl/drop_counter.sv */
// Saturating-free wrap counter with sticky wrap flag and clear on read.
`timescale 1ns/10ps
module drop_counter #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  drop_evt_if.ctr port
);
  logic [W-1:0] count_ff;
  logic wrapped_ff;
  logic at_max;

  assign at_max = (count_ff == {W{1'b1}});
  assign port.count = count_ff;
  assign port.wrapped = wrapped_ff;
  assign port.wrap_pulse = port.drop && at_max;

  // A drop coinciding with a read-clear starts the new count at one.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_ff <= '0;
    end else if (port.rd_clr) begin
      count_ff <= port.drop ? W'(1) : '0;
    end else if (port.drop) begin
      count_ff <= count_ff + W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wrapped_ff <= 1'b0;
    end else if (port.drop && at_max) begin
      wrapped_ff <= 1'b1;
    end else if (port.rd_clr) begin
      wrapped_ff <= 1'b0;
    end
  end
endmodule

/* File: hdl/desc_pointer.sv */
// Read-only current descriptor pointer updated by the DMA engine only.
`timescale 1ns/10ps
module desc_pointer (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic load_in,
  input wire logic [31:0] addr_in,
  output logic [31:0] ptr_out
);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ptr_out <= dma_diag_pkg::PTR_RESET;
    end else if (load_in) begin
      ptr_out <= addr_in;
    end
  end
endmodule

/* File: hdl/eth_dma_diag.sv */
// Ethernet DMA receive drop counters and current descriptor pointers with register port.
//
// Behaviour
// - Each frame dropped for lack of a host receive buffer adds one to the 16-bit count.
// - A no-buffer drop at the maximum count wraps it to zero and sets the flag in bit 16.
// - Frames lost to FIFO overflow or dropped as runts are counted in bits 27 to 17.
// - A FIFO drop at the maximum count wraps it to zero and sets the flag in bit 28.
// - Bits 31 to 29 of the drop counter register always read as zero.
// - A read-only pointer shows the transmit descriptor the DMA is reading.
// - A read-only pointer shows the receive descriptor the DMA is reading.
// - Both pointers reset to zero, change only by the DMA and ignore software writes.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module eth_dma_diag (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic nobuf_drop_in,
  input wire logic fifo_drop_in,
  input wire logic runt_drop_in,
  input wire logic tx_desc_load_in,
  input wire logic [31:0] tx_desc_addr_in,
  input wire logic rx_desc_load_in,
  input wire logic [31:0] rx_desc_addr_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out
);
  // ==========================================================
  // Drop counters
  logic drop_cnt_rd;
  logic [31:0] cur_tx_desc_addr;
  logic [31:0] cur_rx_desc_addr;
  logic [3:0] irq_status_ff;
  logic [3:0] irq_mask_ff;
  logic [3:0] irq_events;
  logic [31:0] drop_word;
  logic [31:0] nxt_rdata;
  logic status_rd;
  logic mask_wr;

  // ==========================================================
  // Address decode
  // A strobe hits a register only when the address matches its offset.
  function automatic logic reg_hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
    return stb && (a == off);
  endfunction

  drop_evt_if #(.W(dma_diag_pkg::NOBUF_W)) nobuf_if();
  drop_evt_if #(.W(dma_diag_pkg::FIFO_W)) fifo_if();

  assign drop_cnt_rd = reg_hit(rd_in, addr_in, dma_diag_pkg::OFF_DROP_CNT);
  assign nobuf_if.drop = nobuf_drop_in;
  assign nobuf_if.rd_clr = drop_cnt_rd;
  assign fifo_if.drop = fifo_drop_in || runt_drop_in;
  assign fifo_if.rd_clr = drop_cnt_rd;

  drop_counter #(.W(dma_diag_pkg::NOBUF_W)) u_nobuf_ctr (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .port(nobuf_if.ctr)
  );

  drop_counter #(.W(dma_diag_pkg::FIFO_W)) u_fifo_ctr (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .port(fifo_if.ctr)
  );

  // ==========================================================
  // Descriptor pointers
  desc_pointer u_tx_ptr (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .load_in(tx_desc_load_in),
    .addr_in(tx_desc_addr_in),
    .ptr_out(cur_tx_desc_addr)
  );

  desc_pointer u_rx_ptr (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .load_in(rx_desc_load_in),
    .addr_in(rx_desc_addr_in),
    .ptr_out(cur_rx_desc_addr)
  );

  // ==========================================================
  // Interrupts
  assign irq_events[dma_diag_pkg::IRQ_NOBUF_DROP] = nobuf_drop_in;
  assign irq_events[dma_diag_pkg::IRQ_NOBUF_WRAP] = nobuf_if.wrap_pulse;
  assign irq_events[dma_diag_pkg::IRQ_FIFO_DROP] = fifo_if.drop;
  assign irq_events[dma_diag_pkg::IRQ_FIFO_WRAP] = fifo_if.wrap_pulse;

  assign status_rd = reg_hit(rd_in, addr_in, dma_diag_pkg::OFF_IRQ_STATUS);
  assign mask_wr = reg_hit(wr_in, addr_in, dma_diag_pkg::OFF_IRQ_MASK);

  // An event in the cycle of the clearing read stays set.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status_ff <= 4'h0;
    end else if (status_rd) begin
      irq_status_ff <= irq_events;
    end else begin
      irq_status_ff <= irq_status_ff | irq_events;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_mask_ff <= dma_diag_pkg::IRQ_MASK_RESET;
    end else if (mask_wr) begin
      irq_mask_ff <= wdata_in[3:0];
    end
  end

  assign irq_out = |(irq_status_ff & irq_mask_ff);

  // ==========================================================
  // Register read port
  always_comb begin
    drop_word = 32'h0000_0000;
    drop_word[dma_diag_pkg::NOBUF_LSB +: dma_diag_pkg::NOBUF_W] = nobuf_if.count;
    drop_word[dma_diag_pkg::NOBUF_WRAP_BIT] = nobuf_if.wrapped;
    drop_word[dma_diag_pkg::FIFO_LSB +: dma_diag_pkg::FIFO_W] = fifo_if.count;
    drop_word[dma_diag_pkg::FIFO_WRAP_BIT] = fifo_if.wrapped;
  end

  // Pointer offsets take no write path at all.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        dma_diag_pkg::OFF_DROP_CNT: nxt_rdata = drop_word;
        dma_diag_pkg::OFF_CUR_TX_DESC: nxt_rdata = cur_tx_desc_addr;
        dma_diag_pkg::OFF_CUR_RX_DESC: nxt_rdata = cur_rx_desc_addr;
        dma_diag_pkg::OFF_IRQ_STATUS: nxt_rdata = {28'h0000000, irq_status_ff};
        dma_diag_pkg::OFF_IRQ_MASK: nxt_rdata = {28'h0000000, irq_mask_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= nxt_rdata;
    end
  end

  // ==========================================================
  // Assertions
  property p_nobuf_inc;
    @(posedge clk_in) disable iff (!reset_n_in)
      nobuf_drop_in && !drop_cnt_rd && !nobuf_if.wrap_pulse
      |=> nobuf_if.count == $past(nobuf_if.count) + 16'h0001;
  endproperty
  a_nobuf_inc: assert property (p_nobuf_inc) else $error("no-buffer count missed a step");

  property p_nobuf_wrap;
    @(posedge clk_in) disable iff (!reset_n_in)
      nobuf_drop_in && nobuf_if.count == dma_diag_pkg::NOBUF_MAX && !drop_cnt_rd
      |=> nobuf_if.count == 16'h0000 && nobuf_if.wrapped;
  endproperty
  a_nobuf_wrap: assert property (p_nobuf_wrap) else $error("no-buffer wrap wrong");

  property p_fifo_inc;
    @(posedge clk_in) disable iff (!reset_n_in)
      (fifo_drop_in || runt_drop_in) && !drop_cnt_rd && !fifo_if.wrap_pulse
      |=> fifo_if.count == $past(fifo_if.count) + 11'h001;
  endproperty
  a_fifo_inc: assert property (p_fifo_inc) else $error("fifo drop count missed a step");

  property p_fifo_wrap;
    @(posedge clk_in) disable iff (!reset_n_in)
      fifo_if.drop && fifo_if.count == dma_diag_pkg::FIFO_MAX && !drop_cnt_rd
      |=> fifo_if.count == 11'h000 && fifo_if.wrapped;
  endproperty
  a_fifo_wrap: assert property (p_fifo_wrap) else $error("fifo wrap wrong");

  property p_reserved_zero;
    @(posedge clk_in) disable iff (!reset_n_in)
      $past(drop_cnt_rd) |-> rdata_out[31:29] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_tx_ptr;
    @(posedge clk_in) disable iff (!reset_n_in)
      tx_desc_load_in |=> cur_tx_desc_addr == $past(tx_desc_addr_in);
  endproperty
  a_tx_ptr: assert property (p_tx_ptr) else $error("tx pointer not loaded");

  property p_rx_ptr;
    @(posedge clk_in) disable iff (!reset_n_in)
      rx_desc_load_in |=> cur_rx_desc_addr == $past(rx_desc_addr_in);
  endproperty
  a_rx_ptr: assert property (p_rx_ptr) else $error("rx pointer not loaded");

  property p_ptr_stable;
    @(posedge clk_in) disable iff (!reset_n_in)
      !tx_desc_load_in && !rx_desc_load_in
      |=> $stable(cur_tx_desc_addr) && $stable(cur_rx_desc_addr);
  endproperty
  a_ptr_stable: assert property (p_ptr_stable) else $error("pointer changed without DMA");

  property p_read_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
      drop_cnt_rd && !nobuf_drop_in
      |=> rdata_out[15:0] == $past(nobuf_if.count) && nobuf_if.count == 16'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear count");

  property p_read_keep;
    @(posedge clk_in) disable iff (!reset_n_in)
      drop_cnt_rd && nobuf_drop_in |=> nobuf_if.count == 16'h0001;
  endproperty
  a_read_keep: assert property (p_read_keep) else $error("drop lost during read");

  // ==========================================================
  // Counter hold and flag assertions
  property p_nobuf_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
      !nobuf_drop_in && !drop_cnt_rd |=> $stable(nobuf_if.count);
  endproperty
  a_nobuf_hold: assert property (p_nobuf_hold) else $error("no-buffer count moved");

  property p_fifo_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
      !fifo_if.drop && !drop_cnt_rd |=> $stable(fifo_if.count);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("fifo count moved");

  property p_nobuf_sticky;
    @(posedge clk_in) disable iff (!reset_n_in)
      nobuf_if.wrapped && !drop_cnt_rd |=> nobuf_if.wrapped;
  endproperty
  a_nobuf_sticky: assert property (p_nobuf_sticky) else $error("no-buffer flag lost");

  property p_fifo_sticky;
    @(posedge clk_in) disable iff (!reset_n_in)
      fifo_if.wrapped && !drop_cnt_rd |=> fifo_if.wrapped;
  endproperty
  a_fifo_sticky: assert property (p_fifo_sticky) else $error("fifo flag lost");

  property p_nobuf_no_flag;
    @(posedge clk_in) disable iff (!reset_n_in)
      !nobuf_if.wrapped && !nobuf_if.wrap_pulse |=> !nobuf_if.wrapped;
  endproperty
  a_nobuf_no_flag: assert property (p_nobuf_no_flag) else $error("no-buffer flag set");

  property p_fifo_no_flag;
    @(posedge clk_in) disable iff (!reset_n_in)
      !fifo_if.wrapped && !fifo_if.wrap_pulse |=> !fifo_if.wrapped;
  endproperty
  a_fifo_no_flag: assert property (p_fifo_no_flag) else $error("fifo flag set");

  // ==========================================================
  // Register port assertions
  property p_read_fields;
    @(posedge clk_in) disable iff (!reset_n_in)
      drop_cnt_rd |=> rdata_out[dma_diag_pkg::NOBUF_WRAP_BIT] == $past(nobuf_if.wrapped)
        && rdata_out[dma_diag_pkg::FIFO_LSB +: dma_diag_pkg::FIFO_W] == $past(fifo_if.count)
        && rdata_out[dma_diag_pkg::FIFO_WRAP_BIT] == $past(fifo_if.wrapped);
  endproperty
  a_read_fields: assert property (p_read_fields) else $error("drop word fields wrong");

  property p_fifo_read_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
      drop_cnt_rd && !fifo_if.drop |=> fifo_if.count == 11'h000;
  endproperty
  a_fifo_read_clear: assert property (p_fifo_read_clear) else $error("fifo count kept");

  property p_fifo_read_keep;
    @(posedge clk_in) disable iff (!reset_n_in)
      drop_cnt_rd && fifo_if.drop |=> fifo_if.count == 11'h001;
  endproperty
  a_fifo_read_keep: assert property (p_fifo_read_keep) else $error("fifo drop lost");

  property p_flag_read_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
      drop_cnt_rd && !nobuf_if.wrap_pulse && !fifo_if.wrap_pulse
      |=> !nobuf_if.wrapped && !fifo_if.wrapped;
  endproperty
  a_flag_read_clear: assert property (p_flag_read_clear) else $error("flags kept");

  property p_tx_ptr_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      reg_hit(rd_in, addr_in, dma_diag_pkg::OFF_CUR_TX_DESC)
      |=> rdata_out == $past(cur_tx_desc_addr);
  endproperty
  a_tx_ptr_read: assert property (p_tx_ptr_read) else $error("tx pointer read wrong");

  property p_rx_ptr_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      reg_hit(rd_in, addr_in, dma_diag_pkg::OFF_CUR_RX_DESC)
      |=> rdata_out == $past(cur_rx_desc_addr);
  endproperty
  a_rx_ptr_read: assert property (p_rx_ptr_read) else $error("rx pointer read wrong");

  property p_rdata_idle;
    @(posedge clk_in) disable iff (!reset_n_in)
      !rd_in |=> rdata_out == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");

  property p_status_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      status_rd |=> rdata_out == {28'h0000000, $past(irq_status_ff)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_mask_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      reg_hit(rd_in, addr_in, dma_diag_pkg::OFF_IRQ_MASK)
      |=> rdata_out == {28'h0000000, $past(irq_mask_ff)};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  // ==========================================================
  // Interrupt assertions
  property p_status_set;
    @(posedge clk_in) disable iff (!reset_n_in)
      |irq_events |=> (irq_status_ff & $past(irq_events)) == $past(irq_events);
  endproperty
  a_status_set: assert property (p_status_set) else $error("status event lost");

  property p_status_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
      status_rd && !(|irq_events) |=> irq_status_ff == 4'h0;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_mask_write;
    @(posedge clk_in) disable iff (!reset_n_in)
      mask_wr |=> irq_mask_ff == $past(wdata_in[3:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  c_nobuf_wrap: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    nobuf_if.wrap_pulse);
  c_fifo_wrap: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    fifo_if.wrap_pulse);
  c_read_collide: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    drop_cnt_rd && nobuf_drop_in);
  c_irq: cover property (@(posedge clk_in) disable iff (!reset_n_in) irq_out);
  c_runt_fifo: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    fifo_drop_in && runt_drop_in);
endmodule

/* File: verif/dma_side_model.sv */
// Model of the DMA engine side that reports frame drops and descriptor fetches.
`timescale 1ns/10ps
module dma_side_model (
  input wire logic clk_in,
  output logic nobuf_drop_out,
  output logic fifo_drop_out,
  output logic runt_drop_out,
  output logic tx_load_out,
  output logic [31:0] tx_addr_out,
  output logic rx_load_out,
  output logic [31:0] rx_addr_out
);
  initial begin
    {runt_drop_out, fifo_drop_out, nobuf_drop_out} = 3'h0;
    {tx_load_out, rx_load_out} = 2'h0;
    tx_addr_out = 32'h0000_0000;
    rx_addr_out = 32'hFFFF_FFFF;
  end

  // ==========================================================
  // Drop events
  // The mask picks runt, fifo and no-buffer drops, held for n cycles.
  task automatic drops(input logic [2:0] which, input int n);
    repeat (n) begin
      @(posedge clk_in);
      {runt_drop_out, fifo_drop_out, nobuf_drop_out} <= which;
    end
    @(posedge clk_in);
    {runt_drop_out, fifo_drop_out, nobuf_drop_out} <= 3'h0;
  endtask

  // ==========================================================
  // Descriptor fetches
  // The address bus shows the inverse value once released, so a pointer must hold.
  task automatic fetch(input logic is_rx, input logic [31:0] a);
    @(posedge clk_in);
    if (is_rx) begin
      rx_load_out <= 1'b1;
      rx_addr_out <= a;
    end else begin
      tx_load_out <= 1'b1;
      tx_addr_out <= a;
    end
    @(posedge clk_in);
    {tx_load_out, rx_load_out} <= 2'h0;
    if (is_rx) rx_addr_out <= ~a;
    else tx_addr_out <= ~a;
  endtask
endmodule

/* File: verif/eth_dma_diag_test.sv */
// Self-checking testbench of the Ethernet DMA drop counters and descriptor pointers.
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module eth_dma_diag_test;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic nobuf, fifo, runt, tx_ld, rx_ld;
  logic [31:0] tx_a, rx_a;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_out;
  logic irq_out;
  int fail_count = 0;
  int samples_checked = 0;

  always #50 clk_in = ~clk_in;

  dma_side_model u_dma (.clk_in(clk_in), .nobuf_drop_out(nobuf), .fifo_drop_out(fifo),
    .runt_drop_out(runt), .tx_load_out(tx_ld), .tx_addr_out(tx_a), .rx_load_out(rx_ld),
    .rx_addr_out(rx_a));
  eth_dma_diag u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .nobuf_drop_in(nobuf),
    .fifo_drop_in(fifo), .runt_drop_in(runt), .tx_desc_load_in(tx_ld),
    .tx_desc_addr_in(tx_a), .rx_desc_load_in(rx_ld), .rx_desc_addr_in(rx_a),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out),
    .irq_out(irq_out));

  // ==========================================================
  // Register bus
  task automatic rd_chk(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    `CHK(irq_out, 1'b0)
    rd_chk(dma_diag_pkg::OFF_DROP_CNT, d); `CHK(d, 32'h0000_0000)
    rd_chk(dma_diag_pkg::OFF_CUR_TX_DESC, d); `CHK(d, dma_diag_pkg::PTR_RESET)
    rd_chk(dma_diag_pkg::OFF_CUR_RX_DESC, d); `CHK(d, dma_diag_pkg::PTR_RESET)
    rd_chk(8'h20, d); `CHK(d, 32'h0000_0000)
  endtask

  task automatic t_pointers();
    logic [31:0] d;
    u_dma.fetch(1'b0, 32'h2000_0A40);
    u_dma.fetch(1'b1, 32'h2000_1C80);
    wr_reg(dma_diag_pkg::OFF_CUR_TX_DESC, 32'hFFFF_FFFF);
    wr_reg(dma_diag_pkg::OFF_CUR_RX_DESC, 32'h1234_5678);
    rd_chk(dma_diag_pkg::OFF_CUR_TX_DESC, d); `CHK(d, 32'h2000_0A40)
    rd_chk(dma_diag_pkg::OFF_CUR_RX_DESC, d); `CHK(d, 32'h2000_1C80)
  endtask

  task automatic t_counts();
    logic [31:0] d;
    u_dma.drops(3'b001, 3);
    rd_chk(dma_diag_pkg::OFF_DROP_CNT, d); `CHK(d, 32'h0000_0003)
    // A drop that lands on the read edge must show up in the next read.
    fork
      rd_chk(dma_diag_pkg::OFF_DROP_CNT, d);
      u_dma.drops(3'b001, 1);
    join
    `CHK(d, 32'h0000_0000)
    rd_chk(dma_diag_pkg::OFF_DROP_CNT, d); `CHK(d, 32'h0000_0001)
    u_dma.drops(3'b010, 1000);
    u_dma.drops(3'b100, 1000);
    u_dma.drops(3'b110, 1);
    u_dma.drops(3'b010, 46);
    rd_chk(dma_diag_pkg::OFF_DROP_CNT, d); `CHK(d, 32'h0FFE_0000)
    u_dma.drops(3'b010, 2048);
    rd_chk(dma_diag_pkg::OFF_DROP_CNT, d); `CHK(d, 32'h1000_0000)
    u_dma.drops(3'b001, 65536);
    rd_chk(dma_diag_pkg::OFF_DROP_CNT, d); `CHK(d, 32'h0001_0000)
    rd_chk(dma_diag_pkg::OFF_DROP_CNT, d); `CHK(d, 32'h0000_0000)
  endtask

  task automatic t_irq();
    logic [31:0] d;
    rd_chk(dma_diag_pkg::OFF_IRQ_STATUS, d); `CHK(d, 32'h0000_000F)
    wr_reg(dma_diag_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    rd_chk(dma_diag_pkg::OFF_IRQ_MASK, d); `CHK(d, 32'h0000_0001)
    u_dma.drops(3'b010, 1);
    #1 `CHK(irq_out, 1'b0)
    u_dma.drops(3'b001, 1);
    #1 `CHK(irq_out, 1'b1)
    wr_reg(dma_diag_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    #1 `CHK(irq_out, 1'b0)
    rd_chk(dma_diag_pkg::OFF_IRQ_STATUS, d); `CHK(d, 32'h0000_0005)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_pointers();
    t_counts();
    t_irq();
    summarize();
  end

  initial begin
    repeat (90000) @(posedge clk_in);
    fail_count++;
    summarize();
  end
endmodule
